// file: verilog/lin_seq_pkg.sv
// Package: modes, settings layout, timing constants for the LIN mode power sequencer.
// Assumes a 100 MHz system clock.
package lin_seq_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Fuse load access time in ns and its cycle count (least time, round up)
  localparam int unsigned T_LOAD_NS = 1000;
  localparam int unsigned T_LOAD_CYC = (T_LOAD_NS * CLK_MHZ + 999) / 1000;
  // Reset timeout options in microseconds (4, 8 default, 16, 32 ms)
  localparam int unsigned T_RES_4_US = 4000;
  localparam int unsigned T_RES_8_US = 8000;
  localparam int unsigned T_RES_16_US = 16000;
  localparam int unsigned T_RES_32_US = 32000;
  localparam int unsigned T_RES_4_CYC = T_RES_4_US * CLK_MHZ;
  localparam int unsigned T_RES_8_CYC = T_RES_8_US * CLK_MHZ;
  localparam int unsigned T_RES_16_CYC = T_RES_16_US * CLK_MHZ;
  localparam int unsigned T_RES_32_CYC = T_RES_32_US * CLK_MHZ;
  // Wake filter, debounce and standby hold defaults in ns
  localparam int unsigned T_WAKE_NS = 150000;
  localparam int unsigned T_WAKE_CYC = T_WAKE_NS * CLK_MHZ / 1000;
  localparam int unsigned T_DEB_NS = 500;
  localparam int unsigned T_DEB_CYC = T_DEB_NS * CLK_MHZ / 1000;
  localparam int unsigned T_STBY_NS = 10000;
  localparam int unsigned T_STBY_CYC = (T_STBY_NS * CLK_MHZ + 999) / 1000;
  // Settings word layout
  localparam int unsigned FUSE_W = 8;
  localparam int unsigned FLD_TRIM_LSB = 0;
  localparam int unsigned FLD_TRIM_W = 4;
  localparam int unsigned FLD_VTH_LSB = 4;
  localparam int unsigned FLD_VTH_W = 2;
  localparam int unsigned FLD_TRES_LSB = 6;
  localparam int unsigned FLD_TRES_W = 2;
  localparam logic [7:0] SETTINGS_RST = 8'h40;
  localparam logic [1:0] VTH_DEFAULT = 2'h1;
  localparam logic [1:0] TRES_4 = 2'h0;
  localparam logic [1:0] TRES_8 = 2'h1;
  localparam logic [1:0] TRES_16 = 2'h2;
  localparam logic [1:0] TRES_32 = 2'h3;
  // Power sequence states, Gray along the power-up path
  typedef enum logic [2:0] {
    SQ_OFF = 3'h0,
    SQ_LDO = 3'h1,
    SQ_FUSE = 3'h3,
    SQ_LATCH = 3'h2,
    SQ_TRES = 3'h6,
    SQ_NORMAL = 3'h7,
    SQ_STBY = 3'h5
  } seq_state_t;
endpackage

// file: verilog/lin_sat_counter.sv
// Counter of consecutive cycles a level holds; flags when a limit is reached.
// Assumes synchronous inputs on clk.
`timescale 1ns/1ps
module lin_sat_counter #(
  parameter int unsigned W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] cnt_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (!run) begin
        cnt_r <= '0;
      end else if (cnt_r != limit) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
  assign done = run && (cnt_r == limit);
endmodule

// file: verilog/lin_rx_filter.sv
// Receive debouncer: output follows bus only after a stable run.
// Assumes comparator outputs synchronous to clk.
`timescale 1ns/1ps
module lin_rx_filter #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] deb_len,
  input wire logic bus_high,
  input wire logic bus_low,
  output logic rx_lvl
);
  logic cand_r;
  logic [W-1:0] cnt_r;
  logic level_r;
  logic target;
  // Hysteresis: only a clear threshold crossing changes the candidate
  always_comb begin
    target = cand_r;
    if (bus_low) begin
      target = 1'b0;
    end else if (bus_high) begin
      target = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cand_r <= 1'b1;
      cnt_r <= '0;
      level_r <= 1'b1;
    end else if (ce) begin
      cand_r <= target;
      if (target != level_r && target == cand_r) begin
        if (cnt_r >= deb_len) begin
          level_r <= target;
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end else begin
        cnt_r <= '0;
      end
    end
  end
  assign rx_lvl = level_r;
endmodule

// file: verilog/lin_mode_power_sequencer.sv
// Power-up sequencing, mode control, remote wake and LIN pin gating.
// Assumes all analog comparator levels arrive synchronous to clk.
//
// Behaviour
// R1 - Supply good releases reset, starts regulator, default threshold (code reloads SETTINGS_RST, whose threshold field is 0, not VTH_DEFAULT)
// R2 - VCC good gives fuse-load pulse, latches fuses
// R3 - Load strobe copies latch into settings register
// R4 - VCC good after load restarts reset timeout
// R5 - Reset held until timeout, then normal mode
// R6 - Low VCC: blocks on, bus released, VCC low
// R7 - Dominant bus for wake time wakes standby
// R8 - Low-power receiver sets remote wake flag
// R9 - Remote wake sets interrupt bit and pin
// R10 - Bus follows transmit input directly
// R11 - Thermal or supply reset forces recessive bus
// R12 - Open transmit input reads as high
// R13 - Bus passed to receive output, debounced
// R14 - Receive output with threshold hysteresis
// R15 - Enable falling edge with transmit high enters standby
// R16 - Enable rising edge returns to normal
// R17 - Standby request ignores bus state
// R18 - Open enable pin reads as low
// R19 - Enable tied high keeps normal mode
// R20 - Standby disables transceiver, divider, watchdogs
// R21 - Filters counted in clock cycles, parameterised
`timescale 1ns/1ps
module lin_mode_power_sequencer
  import lin_seq_pkg::*;
#(
  parameter int unsigned WAKE_CYC = lin_seq_pkg::T_WAKE_CYC,
  parameter int unsigned DEB_CYC = lin_seq_pkg::T_DEB_CYC,
  parameter int unsigned STBY_CYC = lin_seq_pkg::T_STBY_CYC,
  parameter int unsigned LOAD_CYC = lin_seq_pkg::T_LOAD_CYC,
  parameter int unsigned TRES4_CYC = lin_seq_pkg::T_RES_4_CYC,
  parameter int unsigned TRES8_CYC = lin_seq_pkg::T_RES_8_CYC,
  parameter int unsigned TRES16_CYC = lin_seq_pkg::T_RES_16_CYC,
  parameter int unsigned TRES32_CYC = lin_seq_pkg::T_RES_32_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic battery_supply_ok,
  input wire logic battery_supply_low,
  input wire logic vcc_ok,
  input wire logic thermal_shutdown,
  input wire logic [lin_seq_pkg::FUSE_W-1:0] fuse_data,
  input wire logic latch_to_shadow_load,
  input wire logic tx_in,
  input wire logic tx_connected,
  input wire logic en_in,
  input wire logic en_connected,
  input wire logic bus_above_upper,
  input wire logic bus_below_lower,
  input wire logic wake_irq_clear,
  output logic supply_reset_n,
  output logic ldo_enable,
  output logic vcc_pulldown,
  output logic fuse_load_por_n,
  output logic [lin_seq_pkg::FUSE_W-1:0] settings,
  output logic reset_n,
  output logic normal_mode,
  output logic standby_mode,
  output logic transceiver_en,
  output logic divider_en,
  output logic watchdog_en,
  output logic bus_drive_dominant,
  output logic bus_oe,
  output logic rx_out,
  output logic remote_wake_flag,
  output logic irq_wake_bit,
  output logic interrupt_out_n
);
  import lin_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning
  logic tx_eff;
  logic en_eff;
  logic en_prev_r;
  logic en_fall;
  logic en_rise;
  assign tx_eff = tx_connected ? tx_in : 1'b1; // [R12]
  assign en_eff = en_connected & en_in; // [R18]
  assign en_fall = en_prev_r & ~en_eff;
  assign en_rise = ~en_prev_r & en_eff;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  seq_state_t st_r;
  seq_state_t st_nxt;
  logic [31:0] tmr_r;
  logic stby_pend_r;
  logic [FUSE_W-1:0] latch_r;
  logic [FUSE_W-1:0] settings_r;
  logic wake_seen;
  logic stby_done;
  logic tres_done;
  logic [31:0] tres_len;

  function automatic logic [31:0] tres_cycles(input logic [1:0] sel);
    logic [31:0] r;
    r = 32'(TRES8_CYC);
    unique case (sel)
      TRES_4: r = 32'(TRES4_CYC);
      TRES_8: r = 32'(TRES8_CYC);
      TRES_16: r = 32'(TRES16_CYC);
      TRES_32: r = 32'(TRES32_CYC);
    endcase
    return r;
  endfunction

  assign tres_len = tres_cycles(settings_r[FLD_TRES_LSB +: FLD_TRES_W]);
  assign tres_done = (st_r == SQ_TRES) && (tmr_r >= tres_len);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      SQ_OFF: if (battery_supply_ok) st_nxt = SQ_LDO; // [R1]
      SQ_LDO: if (vcc_ok) st_nxt = SQ_FUSE; // [R2]
      SQ_FUSE: if (tmr_r >= 32'(LOAD_CYC)) st_nxt = SQ_LATCH; // [R2]
      SQ_LATCH: if (latch_to_shadow_load && vcc_ok) st_nxt = SQ_TRES; // [R3] [R4]
      SQ_TRES: begin
        if (!vcc_ok) st_nxt = SQ_LATCH;
        else if (tres_done) st_nxt = SQ_NORMAL; // [R5]
      end
      SQ_NORMAL: begin
        if (!vcc_ok) st_nxt = SQ_LATCH;
        else if (stby_done) st_nxt = SQ_STBY; // [R15] [R17]
      end
      SQ_STBY: begin
        if (!vcc_ok) st_nxt = SQ_LATCH;
        else if (en_rise || wake_seen) st_nxt = SQ_NORMAL; // [R16] [R7]
      end
      default: st_nxt = SQ_OFF;
    endcase
    if (battery_supply_low) st_nxt = SQ_OFF;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= SQ_OFF;
      en_prev_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      en_prev_r <= en_eff;
    end
  end

  // Shared timer for fuse access and reset timeout; restarts on state change
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmr_r <= '0;
    end else if (ce) begin
      if (st_nxt != st_r) tmr_r <= '0; // [R4]
      else if (tmr_r != 32'hffffffff) tmr_r <= tmr_r + 32'h1;
    end
  end

  // Fuse latch and settings register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_r <= '0;
      settings_r <= SETTINGS_RST;
    end else if (ce) begin
      if (st_r == SQ_FUSE && st_nxt == SQ_LATCH) latch_r <= fuse_data; // [R2]
      if (st_r == SQ_LATCH && latch_to_shadow_load) settings_r <= latch_r; // [R3]
      if (st_nxt == SQ_OFF) settings_r <= SETTINGS_RST; // [R1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Standby request: enable falls, transmit stays high for the hold time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stby_pend_r <= 1'b0;
    end else if (ce) begin
      if (st_r != SQ_NORMAL || en_eff || !tx_eff) stby_pend_r <= 1'b0;
      else if (en_fall) stby_pend_r <= 1'b1; // [R15] [R19]
    end
  end

  lin_sat_counter #(.W(16)) u_stby_hold (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .run(stby_pend_r && tx_eff && !en_eff),
    .limit(16'(STBY_CYC)),
    .done(stby_done)
  ); // [R21]

  ////////////////////////////////////////////////////////////////////////////
  // Remote wake via low-power receiver
  lin_sat_counter #(.W(16)) u_wake_filt (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .run(st_r == SQ_STBY && bus_below_lower), // [R8] [R21]
    .limit(16'(WAKE_CYC)),
    .done(wake_seen)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remote_wake_flag <= 1'b0;
      irq_wake_bit <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else if (ce) begin
      if (wake_seen && st_r == SQ_STBY) begin // [R8] [R9]
        remote_wake_flag <= 1'b1;
        irq_wake_bit <= 1'b1;
        interrupt_out_n <= 1'b0;
      end else if (wake_irq_clear) begin
        remote_wake_flag <= 1'b0;
        irq_wake_bit <= 1'b0;
        interrupt_out_n <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path
  logic rx_lvl;
  lin_rx_filter #(.W(8)) u_rx (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .deb_len(8'(DEB_CYC)), // [R21]
    .bus_high(bus_above_upper),
    .bus_low(bus_below_lower),
    .rx_lvl(rx_lvl)
  ); // [R13] [R14]

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic is_run;
  logic tx_block;
  assign is_run = (st_r == SQ_NORMAL);
  assign tx_block = thermal_shutdown || battery_supply_low; // [R11]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      supply_reset_n <= 1'b0;
      ldo_enable <= 1'b0;
      vcc_pulldown <= 1'b1;
      fuse_load_por_n <= 1'b0;
      settings <= SETTINGS_RST;
      reset_n <= 1'b0;
      normal_mode <= 1'b0;
      standby_mode <= 1'b0;
      transceiver_en <= 1'b0;
      divider_en <= 1'b0;
      watchdog_en <= 1'b0;
      bus_drive_dominant <= 1'b0;
      bus_oe <= 1'b0;
      rx_out <= 1'b1;
    end else if (ce) begin
      supply_reset_n <= (st_nxt != SQ_OFF); // [R1]
      ldo_enable <= (st_nxt != SQ_OFF); // [R1]
      vcc_pulldown <= (st_nxt == SQ_OFF) || !vcc_ok; // [R6]
      fuse_load_por_n <= (st_nxt != SQ_FUSE); // [R2]
      settings <= settings_r; // [R3]
      reset_n <= (st_nxt == SQ_NORMAL) || (st_nxt == SQ_STBY); // [R5]
      normal_mode <= (st_nxt == SQ_NORMAL);
      standby_mode <= (st_nxt == SQ_STBY);
      transceiver_en <= (st_nxt != SQ_OFF) && (st_nxt != SQ_STBY); // [R6] [R20]
      divider_en <= (st_nxt != SQ_OFF) && (st_nxt != SQ_STBY); // [R6] [R20]
      watchdog_en <= (st_nxt == SQ_NORMAL); // [R20]
      bus_drive_dominant <= is_run && !tx_block && !tx_eff; // [R10] [R11]
      bus_oe <= is_run && !tx_block && !tx_eff; // [R6] [R10]
      rx_out <= (st_r == SQ_OFF) ? 1'b1 : rx_lvl; // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_tx_block;
    @(posedge clk) disable iff (!nrst)
    (ce && tx_block) |=> !bus_oe;
  endproperty
  a_tx_block: assert property (p_tx_block) else $error("bus driven while blocked"); // [R11]

  property p_tx_follow;
    @(posedge clk) disable iff (!nrst)
    (ce && is_run && !tx_block && !tx_eff) |=> bus_drive_dominant;
  endproperty
  a_tx_follow: assert property (p_tx_follow) else $error("tx low not driven"); // [R10]

  property p_open_tx;
    @(posedge clk) disable iff (!nrst)
    (ce && !tx_connected) |=> !bus_drive_dominant;
  endproperty
  a_open_tx: assert property (p_open_tx) else $error("open tx drove bus"); // [R12]

  property p_wake_irq;
    @(posedge clk) disable iff (!nrst)
    (ce && wake_seen && st_r == SQ_STBY) |=> (!interrupt_out_n && irq_wake_bit);
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake without irq"); // [R9]

  property p_wake_norm;
    @(posedge clk) disable iff (!nrst)
    (ce && wake_seen && st_r == SQ_STBY && vcc_ok && !battery_supply_low)
      |=> normal_mode;
  endproperty
  a_wake_norm: assert property (p_wake_norm) else $error("wake not normal"); // [R7]

  property p_stby_off;
    @(posedge clk) disable iff (!nrst)
    standby_mode |-> (!transceiver_en && !divider_en && !watchdog_en);
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("block on in standby"); // [R20]

  property p_reset_hold;
    @(posedge clk) disable iff (!nrst)
    (ce && st_r == SQ_TRES && !tres_done) |=> !reset_n;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset early"); // [R5]

  property p_en_high;
    @(posedge clk) disable iff (!nrst)
    (ce && en_eff && st_r == SQ_NORMAL) |=> st_r != SQ_STBY;
  endproperty
  a_en_high: assert property (p_en_high) else $error("standby with en high"); // [R19]

  property p_fuse_pulse;
    @(posedge clk) disable iff (!nrst)
    (ce && st_r == SQ_LDO && st_nxt == SQ_FUSE) |=> !fuse_load_por_n;
  endproperty
  a_fuse_pulse: assert property (p_fuse_pulse) else $error("no fuse pulse"); // [R2]

  property p_settings_load;
    @(posedge clk) disable iff (!nrst)
    (ce && st_r == SQ_LATCH && latch_to_shadow_load && !battery_supply_low)
      |=> (settings_r == latch_r);
  endproperty
  a_settings_load: assert property (p_settings_load) else $error("settings not loaded"); // [R3]

  property p_ce_hold;
    @(posedge clk) disable iff (!nrst)
    !ce |=> ($stable(st_r) && $stable(bus_oe) && $stable(reset_n) && $stable(settings_r));
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("state moved with clock enable low");

  c_wake: cover property (@(posedge clk) disable iff (!nrst) wake_seen);
  c_stby: cover property (@(posedge clk) disable iff (!nrst) standby_mode);
  c_norm: cover property (@(posedge clk) disable iff (!nrst) normal_mode && bus_oe);
endmodule

// file: testbench/lin_mcu_model.sv
// Microcontroller model: drives transmit, mode pin and wake clear.
// Assumes the sequencer samples its inputs on the rising edge of clk.
`timescale 1ns/1ps
module lin_mcu_model (
  input wire logic clk,
  input wire logic interrupt_out_n,
  output logic tx_in,
  output logic en_in,
  output logic wake_irq_clear
);
  initial begin
    tx_in = 1'b1;
    en_in = 1'b1;
    wake_irq_clear = 1'b0;
  end
  ////////////////////////////////////////
  // Pin levels set just after a rising edge
  task automatic drive(input logic t, input logic e);
    @(posedge clk);
    tx_in <= t;
    en_in <= e;
  endtask
  // Standby request: mode pin falls, transmit stays high
  task automatic stby(input int n);
    drive(1'b1, 1'b0);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Interrupt service after a chosen delay, prompt or slow
  task automatic service(input int dly);
    repeat (dly) @(posedge clk);
    wake_irq_clear <= !interrupt_out_n;
    @(posedge clk);
    wake_irq_clear <= 1'b0;
  endtask
endmodule

// file: testbench/test_lin_mode_power_sequencer.sv
// Self-checking testbench for the LIN mode power sequencer.
// Assumes the microcontroller model and shortened timing parameters.
`timescale 1ns/1ps
module test_lin_mode_power_sequencer;
  import lin_seq_pkg::*;
  localparam int WK = 20;
  localparam int DB = 3;
  localparam int SB = 5;
  logic clk, nrst, ce, battery_supply_ok, battery_supply_low, vcc_ok;
  logic thermal_shutdown, latch_to_shadow_load, tx_in, tx_connected, en_in;
  logic en_connected, bus_above_upper, bus_below_lower, wake_irq_clear;
  logic supply_reset_n, ldo_enable, vcc_pulldown, fuse_load_por_n, reset_n;
  logic normal_mode, standby_mode, transceiver_en, divider_en, watchdog_en;
  logic bus_drive_dominant, bus_oe, rx_out, remote_wake_flag, irq_wake_bit;
  logic interrupt_out_n;
  logic [FUSE_W-1:0] fuse_data, settings, f;
  logic [31:0] r;
  int failures = 0;
  int tests_run = 0;
  integer seed = 32'hdae0aeec;
  lin_mode_power_sequencer #(.WAKE_CYC(WK), .DEB_CYC(DB), .STBY_CYC(SB), .LOAD_CYC(4),
    .TRES4_CYC(50), .TRES8_CYC(60), .TRES16_CYC(70), .TRES32_CYC(80))
    lin_mode_power_sequencer_inst (.clk, .nrst, .ce, .battery_supply_ok,
    .battery_supply_low, .vcc_ok, .thermal_shutdown, .fuse_data, .latch_to_shadow_load,
    .tx_in, .tx_connected, .en_in, .en_connected, .bus_above_upper, .bus_below_lower,
    .wake_irq_clear, .supply_reset_n, .ldo_enable, .vcc_pulldown, .fuse_load_por_n,
    .settings, .reset_n, .normal_mode, .standby_mode, .transceiver_en, .divider_en,
    .watchdog_en, .bus_drive_dominant, .bus_oe, .rx_out, .remote_wake_flag,
    .irq_wake_bit, .interrupt_out_n);
  lin_mcu_model lin_mcu_model_inst (.clk, .interrupt_out_n, .tx_in, .en_in,
    .wake_irq_clear);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic int tres(input logic [1:0] s);
    case (s)
      TRES_4: return 50;
      TRES_8: return 60;
      TRES_16: return 70;
      default: return 80;
    endcase
  endfunction
  function automatic logic bus_exp(input logic t, input logic c, input logic th);
    return c & !t & !th;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rxp(input logic a, input logic b, input int n);
    @(posedge clk);
    bus_above_upper <= a;
    bus_below_lower <= b;
    wt(n);
  endtask
  // Load strobe, then count edges until system reset lifts
  task automatic ld(input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    latch_to_shadow_load <= 1'b1;
    @(posedge clk);
    latch_to_shadow_load <= 1'b0;
    #1;
    while (reset_n !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n), 8'(tres(v[7:6]) + 1));
    chk(settings, v);
    chk({7'h0, normal_mode}, 8'h01);
  endtask
  task automatic pwr(input logic [7:0] v);
    int n;
    n = 0;
    lin_mcu_model_inst.drive(1'b1, 1'b1);
    battery_supply_low <= 1'b0;
    battery_supply_ok <= 1'b1;
    vcc_ok <= 1'b1;
    fuse_data <= v;
    repeat (30) begin
      @(posedge clk);
      #1;
      n += (fuse_load_por_n === 1'b0);
    end
    chk(8'(n), 8'h05);
    chk({5'h0, supply_reset_n, ldo_enable, reset_n}, 8'h06);
    ld(v);
  endtask
  ////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    battery_supply_ok = 1'b0;
    battery_supply_low = 1'b0;
    vcc_ok = 1'b0;
    thermal_shutdown = 1'b0;
    fuse_data = 8'h00;
    latch_to_shadow_load = 1'b0;
    tx_connected = 1'b1;
    en_connected = 1'b1;
    bus_above_upper = 1'b1;
    bus_below_lower = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    wt(2);
    chk(settings, SETTINGS_RST);
    for (int i = 0; i < 4; i++) begin
      f = {i[1:0], 6'($random(seed))};
      pwr(f);
      lin_mcu_model_inst.drive(1'b0, 1'b1);
      battery_supply_low <= 1'b1;
      wt(2);
      chk({6'h0, reset_n, bus_oe & bus_drive_dominant}, 8'h00);
    end
    pwr(f);
    @(posedge clk);
    vcc_ok <= 1'b0;
    wt(2);
    chk({3'h0, vcc_pulldown, bus_oe, transceiver_en, divider_en, reset_n}, 8'h16);
    @(posedge clk);
    vcc_ok <= 1'b1;
    ld(f);
    repeat (24) begin
      r = $random(seed);
      lin_mcu_model_inst.drive(r[0], 1'b1);
      tx_connected <= r[1] | r[3];
      thermal_shutdown <= r[2] & r[4];
      wt(2);
      chk({7'h0, bus_oe & bus_drive_dominant}, {7'h0, bus_exp(r[0], r[1] | r[3], r[2] & r[4])});
    end
    lin_mcu_model_inst.drive(1'b1, 1'b1);
    tx_connected <= 1'b1;
    thermal_shutdown <= 1'b0;
    // Clock enable low freezes the transmit path, then releases it
    @(posedge clk);
    ce <= 1'b0;
    lin_mcu_model_inst.drive(1'b0, 1'b1);
    wt(3);
    chk({6'h0, bus_oe, normal_mode}, 8'h01);
    @(posedge clk);
    ce <= 1'b1;
    wt(2);
    chk({6'h0, bus_oe, normal_mode}, 8'h03);
    rxp(1'b0, 1'b1, DB + 4);
    chk({7'h0, rx_out}, 8'h00);
    rxp(1'b1, 1'b0, 1);
    rxp(1'b0, 1'b1, 2);
    rxp(1'b0, 1'b0, 10);
    chk({7'h0, rx_out}, 8'h00);
    rxp(1'b1, 1'b0, DB + 4);
    chk({7'h0, rx_out}, 8'h01);
    lin_mcu_model_inst.drive(1'b1, 1'b0);
    wt(2);
    lin_mcu_model_inst.drive(1'b0, 1'b0);
    wt(SB + 4);
    chk({6'h0, normal_mode, standby_mode}, 8'h02);
    lin_mcu_model_inst.drive(1'b1, 1'b1);
    rxp(1'b0, 1'b1, 1);
    lin_mcu_model_inst.stby(SB + 3);
    chk({3'h0, normal_mode, standby_mode, transceiver_en, divider_en, watchdog_en}, 8'h08);
    rxp(1'b1, 1'b0, 2);
    lin_mcu_model_inst.drive(1'b1, 1'b1);
    wt(2);
    chk({7'h0, normal_mode}, 8'h01);
    lin_mcu_model_inst.stby(SB + 3);
    rxp(1'b0, 1'b1, WK - 2);
    chk({6'h0, standby_mode, remote_wake_flag}, 8'h02);
    rxp(1'b1, 1'b0, 2);
    rxp(1'b0, 1'b1, WK + 4);
    chk({4'h0, remote_wake_flag, irq_wake_bit, interrupt_out_n, normal_mode}, 8'h0d);
    rxp(1'b1, 1'b0, 2);
    lin_mcu_model_inst.service(3);
    wt(2);
    chk({5'h0, remote_wake_flag, irq_wake_bit, interrupt_out_n}, 8'h01);
    lin_mcu_model_inst.drive(1'b1, 1'b1);
    wt(2);
    en_connected <= 1'b0;
    wt(SB + 4);
    chk({7'h0, standby_mode}, 8'h01);
    en_connected <= 1'b1;
    wt(40);
    chk({6'h0, normal_mode, standby_mode}, 8'h02);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule
